// ===== pmx_map.svh
// register offsets, field positions, reset values and timing figures of the power mode block
`ifndef PMX_MAP_SVH
`define PMX_MAP_SVH
`define PMX_ADDR_W 8
`define PMX_OFF_PWR 8'h80
`define PMX_OFF_TCTL 8'h88
`define PMX_OFF_STATUS 8'h8c
`define PMX_OFF_REGCTL 8'hc8
`define PMX_OFF_IRQCFG 8'he4
`define PMX_IRQCFG_RST 8'h01
`define PMX_B_POL 7
`define PMX_B_SEL_HI 6
`define PMX_B_SEL_LO 4
`define PMX_A_POL 3
`define PMX_A_SEL_HI 2
`define PMX_A_SEL_LO 0
`define PMX_PWR_STOP 1
`define PMX_PWR_IDLE 0
`define PMX_PWR_GF_HI 7
`define PMX_PWR_GF_LO 2
`define PMX_REGCTL_OFF 0
`define PMX_TCTL_A_EDGE 0
`define PMX_TCTL_B_EDGE 1
`define PMX_TCTL_LCM_EN 2
`define PMX_RESP_OKAY 2'h0
`define PMX_RESP_SLVERR 2'h2
`define PMX_RESET_VECTOR 16'h0000
`define PMX_CLK_NS 4
`define PMX_RST_SEQ_NS 40
`endif

// ===== pmx_pkg.sv
// types of the power mode and external interrupt block
package pmx_pkg;
  typedef enum logic [1:0] {
    PMX_RUN = 2'h0,
    PMX_IDLE = 2'h1,
    PMX_STOP = 2'h3,
    PMX_RSEQ = 2'h2
  } pmx_mode_t;

  typedef struct packed {
    pmx_mode_t mode;
    logic [7:0] irqcfg;
    logic [5:0] gp_flags;
    logic reg_off_cfg;
    logic lcm_en;
    logic edge_a;
    logic edge_b;
    logic arm_idle;
    logic arm_stop;
    logic [3:0] rst_cnt;
    logic ext_s1;
    logic ext_s2;
    logic ext_s3;
    logic ext_rst;
    logic pend_a;
    logic pend_b;
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic cpu_clk_en;
    logic periph_clk_en;
    logic osc_en;
    logic regulator_en;
    logic sys_reset;
    logic irq_a_req;
    logic irq_b_req;
    logic [7:0] xbar_allow;
    logic [15:0] fetch_addr;
  } pmx_state_t;
endpackage : pmx_pkg

// ===== pmx_irq_detect.sv
// synchroniser, pin selector, polarity and edge detector of one external interrupt
`timescale 1ns/1ns
module pmx_irq_detect #(
  parameter int PINS = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [PINS-1:0] pins,
  input wire logic [2:0] pin_select,
  input wire logic active_high,
  output logic active,
  output logic edge_pulse
);
  import pmx_pkg::*;

  typedef struct packed {
    logic [PINS-1:0] s1;
    logic [PINS-1:0] s2;
    logic [PINS-1:0] s3;
    logic [PINS-1:0] filt;
    logic active;
    logic edge_pulse;
  } pmx_det_t;

  pmx_det_t s;
  pmx_det_t next_s;
  logic sel_bit;

  if (PINS < 2 || PINS > 8) begin : g_bad
    $error("pin count must be 2 to 8");
  end

  // every pin is synchronised, so changing the selection never picks up a metastable bit
  always_comb begin
    next_s = s;
    next_s.s1 = pins;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    for (int i = 0; i < PINS; i++) begin
      if (s.s2[i] == s.s3[i]) begin
        next_s.filt[i] = s.s3[i];
      end
    end
    // only sampled, never driven: the pin owner keeps the pin
    sel_bit = (int'(pin_select) < PINS) ? s.filt[pin_select] : 1'b0;
    next_s.active = active_high ? sel_bit : ~sel_bit;
    next_s.edge_pulse = next_s.active & ~s.active;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      // pins idle high behind their pull-ups; starting there avoids a false edge after reset
      s.s1 <= '1;
      s.s2 <= '1;
      s.s3 <= '1;
      s.filt <= '1;
    end else begin
      s <= next_s;
    end
  end

  assign active = s.active;
  assign edge_pulse = s.edge_pulse;

  a_edge_single: assert property (@(posedge aclk) disable iff (!aresetn)
    s.edge_pulse |=> !s.edge_pulse) else $error("edge pulse longer than one cycle");
  a_edge_follows: assert property (@(posedge aclk) disable iff (!aresetn)
    s.edge_pulse |-> s.active && !$past(s.active)) else $error("edge without activation");
endmodule : pmx_irq_detect

// ===== pmx_power_ctrl.sv
// idle and stop power mode controller with external interrupt configuration over axi4-lite
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ns
`include "pmx_map.svh"
module pmx_power_ctrl #(
  parameter int PINS = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [PINS-1:0] port_pins,
  input wire logic [PINS-1:0] xbar_skip,
  input wire logic instr_done,
  input wire logic [1:0] irq_enable,
  input wire logic other_irq_wake,
  input wire logic vector_ack_a,
  input wire logic vector_ack_b,
  input wire logic wdt_timeout,
  input wire logic lost_clock_timeout,
  input wire logic ext_reset_pin_n,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic osc_en,
  output logic regulator_en,
  output logic sys_reset,
  output logic irq_a_req,
  output logic irq_b_req,
  output logic [PINS-1:0] xbar_allow,
  output logic [15:0] fetch_addr
);
  import pmx_pkg::*;

  localparam int RST_CYC = (`PMX_RST_SEQ_NS + `PMX_CLK_NS - 1) / `PMX_CLK_NS;

  if (PINS != 8) begin : g_bad
    $error("pin select fields and crossbar width serve exactly 8 pins");
  end
  if (RST_CYC < 1 || RST_CYC > 15) begin : g_bad_rst
    $error("reset sequence length does not fit its counter");
  end

  pmx_state_t s;
  pmx_state_t next_s;
  logic act_a;
  logic act_b;
  logic edg_a;
  logic edg_b;
  logic int_rst;
  logic rst_any;
  logic wake;
  logic wr_go;
  logic [7:0] rd_addr;

  pmx_irq_detect #(.PINS(PINS)) u_det_a (
    .aclk(aclk),
    .aresetn(aresetn),
    .pins(port_pins),
    .pin_select(s.irqcfg[`PMX_A_SEL_HI:`PMX_A_SEL_LO]),
    .active_high(s.irqcfg[`PMX_A_POL]),
    .active(act_a),
    .edge_pulse(edg_a)
  );

  pmx_irq_detect #(.PINS(PINS)) u_det_b (
    .aclk(aclk),
    .aresetn(aresetn),
    .pins(port_pins),
    .pin_select(s.irqcfg[`PMX_B_SEL_HI:`PMX_B_SEL_LO]),
    .active_high(s.irqcfg[`PMX_B_POL]),
    .active(act_b),
    .edge_pulse(edg_b)
  );

  function automatic pmx_state_t pmx_soft_reset(input pmx_state_t st);
    pmx_state_t r;
    r = st;
    r.irqcfg = `PMX_IRQCFG_RST;
    r.gp_flags = '0;
    r.reg_off_cfg = 1'b0;
    r.lcm_en = 1'b0;
    r.edge_a = 1'b0;
    r.edge_b = 1'b0;
    r.arm_idle = 1'b0;
    r.arm_stop = 1'b0;
    r.pend_a = 1'b0;
    r.pend_b = 1'b0;
    return r;
  endfunction : pmx_soft_reset

  always_comb begin
    next_s = s;
    rd_addr = s_axi_araddr;
    wr_go = s.aw_got && s.w_got && !s.bvalid;
    // internal reset sources; the watchdog decides itself whether it is enabled
    int_rst = wdt_timeout || (s.lcm_en && lost_clock_timeout);
    // regulator down in stop: internal sources cannot wake the device
    if (s.mode == PMX_STOP && s.reg_off_cfg) begin
      int_rst = 1'b0;
    end
    rst_any = int_rst || s.ext_rst;
    wake = ((irq_a_req && irq_enable[0]) || (irq_b_req && irq_enable[1]) || other_irq_wake);

    // external reset pin through three flops; level counts when the last two agree
    next_s.ext_s1 = ~ext_reset_pin_n;
    next_s.ext_s2 = s.ext_s1;
    next_s.ext_s3 = s.ext_s2;
    if (s.ext_s2 == s.ext_s3) begin
      next_s.ext_rst = s.ext_s3;
    end

    // interrupt flags run in idle, frozen in stop since their clock is halted
    if (s.mode != PMX_STOP) begin
      next_s.pend_a = (s.pend_a && !vector_ack_a) || edg_a;
      next_s.pend_b = (s.pend_b && !vector_ack_b) || edg_b;
    end

    // axi write: address and data taken in either order, response after both
    if (s_axi_awvalid && s.awready) begin
      next_s.awaddr = s_axi_awaddr;
      next_s.aw_got = 1'b1;
      next_s.awready = 1'b0;
    end
    if (s_axi_wvalid && s.wready) begin
      next_s.wdata = s_axi_wdata[7:0];
      next_s.wstrb0 = s_axi_wstrb[0];
      next_s.w_got = 1'b1;
      next_s.wready = 1'b0;
    end
    if (wr_go) begin
      next_s.bvalid = 1'b1;
      next_s.bresp = `PMX_RESP_OKAY;
      case (s.awaddr)
        `PMX_OFF_PWR: begin
          if (s.wstrb0) begin
            next_s.gp_flags = s.wdata[`PMX_PWR_GF_HI:`PMX_PWR_GF_LO];
            next_s.arm_idle = s.wdata[`PMX_PWR_IDLE];
            next_s.arm_stop = s.wdata[`PMX_PWR_STOP];
          end
        end
        `PMX_OFF_IRQCFG: begin
          if (s.wstrb0) begin
            next_s.irqcfg = s.wdata;
          end
        end
        `PMX_OFF_REGCTL: begin
          if (s.wstrb0) begin
            next_s.reg_off_cfg = s.wdata[`PMX_REGCTL_OFF];
          end
        end
        `PMX_OFF_TCTL: begin
          if (s.wstrb0) begin
            next_s.edge_a = s.wdata[`PMX_TCTL_A_EDGE];
            next_s.edge_b = s.wdata[`PMX_TCTL_B_EDGE];
            next_s.lcm_en = s.wdata[`PMX_TCTL_LCM_EN];
          end
        end
        `PMX_OFF_STATUS: begin
        end
        default: begin
          next_s.bresp = `PMX_RESP_SLVERR;
        end
      endcase
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.awready = 1'b1;
      next_s.wready = 1'b1;
    end

    // axi read: one cycle from address to data
    if (s_axi_arvalid && s.arready) begin
      next_s.arready = 1'b0;
      next_s.rvalid = 1'b1;
      next_s.rresp = `PMX_RESP_OKAY;
      next_s.rdata = '0;
      case (rd_addr)
        `PMX_OFF_PWR: next_s.rdata[7:0] = {s.gp_flags, 2'h0};
        `PMX_OFF_IRQCFG: next_s.rdata[7:0] = s.irqcfg;
        `PMX_OFF_REGCTL: next_s.rdata[`PMX_REGCTL_OFF] = s.reg_off_cfg;
        `PMX_OFF_TCTL: next_s.rdata[7:0] = {5'h00, s.lcm_en, s.edge_b, s.edge_a};
        `PMX_OFF_STATUS: next_s.rdata[7:0] = {3'h0, s.regulator_en, s.irq_b_req, s.irq_a_req,
                                              s.mode};
        default: next_s.rresp = `PMX_RESP_SLVERR;
      endcase
    end
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
      next_s.arready = 1'b1;
    end

    // power mode sequencing
    case (s.mode)
      PMX_RUN: begin
        if (rst_any) begin
          next_s.mode = PMX_RSEQ;
        end else if (instr_done && s.arm_stop) begin
          next_s.mode = PMX_STOP;
          next_s.arm_stop = 1'b0;
          next_s.arm_idle = 1'b0;
        end else if (instr_done && s.arm_idle) begin
          next_s.mode = PMX_IDLE;
        end
      end
      PMX_IDLE: begin
        if (rst_any) begin
          next_s.mode = PMX_RSEQ;
        end else if (wake) begin
          // the cpu resumes where it stopped, so return lands after the idle write
          next_s.mode = PMX_RUN;
          next_s.arm_idle = 1'b0;
        end
      end
      PMX_STOP: begin
        // interrupts are deliberately not looked at here
        if (rst_any) begin
          next_s.mode = PMX_RSEQ;
        end
      end
      PMX_RSEQ: begin
        if (s.rst_cnt == 4'(RST_CYC - 1)) begin
          next_s.mode = PMX_RUN;
        end
      end
      default: begin
        next_s.mode = PMX_RSEQ;
      end
    endcase

    if (next_s.mode == PMX_RSEQ) begin
      next_s = pmx_soft_reset(next_s);
      next_s.rst_cnt = (s.mode == PMX_RSEQ) ? s.rst_cnt + 4'h1 : 4'h0;
    end else begin
      next_s.rst_cnt = 4'h0;
    end

    next_s.sys_reset = (next_s.mode == PMX_RSEQ);
    next_s.fetch_addr = `PMX_RESET_VECTOR;
    next_s.cpu_clk_en = (next_s.mode == PMX_RUN);
    next_s.periph_clk_en = (next_s.mode != PMX_STOP);
    next_s.osc_en = (next_s.mode != PMX_STOP);
    next_s.regulator_en = !(next_s.mode == PMX_STOP && s.reg_off_cfg);
    next_s.irq_a_req = next_s.edge_a ? next_s.pend_a : act_a;
    next_s.irq_b_req = next_s.edge_b ? next_s.pend_b : act_b;
    next_s.xbar_allow = ~xbar_skip;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= pmx_soft_reset('0);
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
      s.cpu_clk_en <= 1'b1;
      s.periph_clk_en <= 1'b1;
      s.osc_en <= 1'b1;
      s.regulator_en <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign cpu_clk_en = s.cpu_clk_en;
  assign periph_clk_en = s.periph_clk_en;
  assign osc_en = s.osc_en;
  assign regulator_en = s.regulator_en;
  assign sys_reset = s.sys_reset;
  assign irq_a_req = s.irq_a_req;
  assign irq_b_req = s.irq_b_req;
  assign xbar_allow = s.xbar_allow;
  assign fetch_addr = s.fetch_addr;

  a_stop_no_wake: assert property (@(posedge aclk) disable iff (!aresetn)
    (s.mode == PMX_STOP && wake && !rst_any) |=> s.mode == PMX_STOP)
    else $error("interrupt woke the device from stop");
  a_idle_irq_wake: assert property (@(posedge aclk) disable iff (!aresetn)
    (s.mode == PMX_IDLE && wake && !rst_any) |=> (s.mode == PMX_RUN && s.cpu_clk_en))
    else $error("enabled interrupt did not end idle");
  a_idle_entry: assert property (@(posedge aclk) disable iff (!aresetn)
    (s.mode == PMX_RUN && instr_done && s.arm_idle && !s.arm_stop && !rst_any)
    |=> (s.mode == PMX_IDLE && !s.cpu_clk_en && s.periph_clk_en))
    else $error("idle not entered after the instruction ended");
  a_regoff_blocks_int: assert property (@(posedge aclk) disable iff (!aresetn)
    (s.mode == PMX_STOP && s.reg_off_cfg && !s.ext_rst) |=> s.mode == PMX_STOP)
    else $error("internal reset woke a stop with regulator off");
  a_regoff_drop: assert property (@(posedge aclk) disable iff (!aresetn)
    (s.mode == PMX_STOP) |-> (s.regulator_en == !s.reg_off_cfg))
    else $error("regulator state in stop is wrong");
  a_pwr_read_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s.arready && s_axi_araddr == `PMX_OFF_PWR)
    |=> (s.rvalid && s.rdata[1:0] == 2'h0)) else $error("mode select bits read nonzero");
  a_reset_seq_len: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(s.sys_reset) |-> (s.sys_reset && s.fetch_addr == `PMX_RESET_VECTOR) [*8])
    else $error("reset sequence shorter than expected");
  a_xbar_skip: assert property (@(posedge aclk) disable iff (!aresetn)
    aresetn |=> s.xbar_allow == ~$past(xbar_skip)) else $error("skipped pin still routed");
  a_pend_set_wins: assert property (@(posedge aclk) disable iff (!aresetn)
    (edg_a && vector_ack_a && s.mode != PMX_STOP && next_s.mode != PMX_RSEQ) |=> s.pend_a)
    else $error("edge lost against vector clear");
endmodule : pmx_power_ctrl

// ===== pmx_fix_note_unused.sv
// no logic of its own: the block lives in the other files

// ===== pmx_pin_src.sv
// model of the external interrupt sources driving the port pins
`timescale 1ns/1ns
module pmx_pin_src (
  input wire logic aclk,
  input wire logic [7:0] level_cmd,
  output logic [7:0] port_pins
);
  // pins move 1 ns after the edge, so the synchroniser sees a truly late input
  initial port_pins = 8'hff;
  always @(posedge aclk) begin
    port_pins <= #1 level_cmd;
  end
endmodule : pmx_pin_src

// ===== power_mode_and_ext_irq_config_test.sv
// self-checking bench of the power mode and external interrupt block
`timescale 1ns/1ns
module power_mode_and_ext_irq_config_test;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, instr_done, other_irq_wake;
  logic vector_ack_a, vector_ack_b, wdt_timeout, lost_clock_timeout, ext_reset_pin_n;
  logic cpu_clk_en, periph_clk_en, osc_en, regulator_en, sys_reset, irq_a_req, irq_b_req;
  logic [7:0] awaddr, araddr, xbar_skip, xbar_allow, pins_cmd, port_pins;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, irq_enable;
  logic [15:0] fetch_addr;
  int miscompares = 0;
  int total_checks = 0;

  pmx_pin_src src (.aclk(aclk), .level_cmd(pins_cmd), .port_pins(port_pins));

  pmx_power_ctrl #(.PINS(8)) DUT (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .port_pins(port_pins), .xbar_skip(xbar_skip), .instr_done(instr_done),
    .irq_enable(irq_enable), .other_irq_wake(other_irq_wake),
    .vector_ack_a(vector_ack_a), .vector_ack_b(vector_ack_b), .wdt_timeout(wdt_timeout),
    .lost_clock_timeout(lost_clock_timeout), .ext_reset_pin_n(ext_reset_pin_n),
    .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .osc_en(osc_en),
    .regulator_en(regulator_en), .sys_reset(sys_reset), .irq_a_req(irq_a_req),
    .irq_b_req(irq_b_req), .xbar_allow(xbar_allow), .fetch_addr(fetch_addr));

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task chkb(input logic g, input logic e);
    chk({31'h0, g}, {31'h0, e});
  endtask : chkb

  // ready is registered, so its value at the falling edge is what the next rising edge sees
  task axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic ta, tw, b;
    b = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      b = bvalid;
      if (b) chk({30'h0, bresp}, {30'h0, er});
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask : axi_wr

  task axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ta, r;
    r = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r) begin
      @(negedge aclk);
      ta = arvalid && arready;
      r = rvalid;
      if (r) chk(rdata, ed);
      if (r) chk({30'h0, rresp}, {30'h0, er});
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask : axi_rd

  task enter(input logic [7:0] d);
    axi_wr(8'h80, d, 2'h0);
    @(posedge aclk);
    instr_done <= 1'b1;
    @(posedge aclk);
    instr_done <= 1'b0;
    repeat (3) @(negedge aclk);
  endtask : enter

  // counts the cycles of the internal reset sequence, releasing every reset cause meanwhile
  task rst_seq;
    int n;
    n = 0;
    for (int i = 0; i < 30; i++) begin
      @(posedge aclk);
      if (i == 6) begin
        wdt_timeout <= 1'b0;
        lost_clock_timeout <= 1'b0;
        ext_reset_pin_n <= 1'b1;
      end
      @(negedge aclk);
      if (sys_reset === 1'b1) n++;
    end
    chk(n, 32'd10);
    chkb(cpu_clk_en, 1'b1);
    chk({16'h0, fetch_addr}, 32'h0);
  endtask : rst_seq

  task test_regs;
    axi_rd(8'he4, 32'h01, 2'h0);
    axi_rd(8'h8c, 32'h10, 2'h0);
    axi_wr(8'h80, 8'hfc, 2'h0);
    axi_rd(8'h80, 32'hfc, 2'h0);
    axi_wr(8'h40, 8'h55, 2'h2);
    axi_rd(8'h40, 32'h0, 2'h2);
    $display("register test done");
  endtask : test_regs

  task test_xbar;
    @(posedge aclk);
    xbar_skip <= 8'h5a;
    pins_cmd <= 8'h00;
    repeat (3) @(negedge aclk);
    chk({24'h0, xbar_allow}, 32'ha5);
    @(posedge aclk);
    pins_cmd <= 8'hff;
    repeat (8) @(negedge aclk);
    chk({24'h0, xbar_allow}, 32'ha5);
    $display("crossbar test done");
  endtask : test_xbar

  task test_pins;
    logic [7:0] c, p;
    for (int i = 0; i < 8; i++) begin
      for (int k = 0; k < 2; k++) begin
        c = {k[0], i[2:0], k[0], i[2:0]};
        p = 8'h01 << i;
        axi_wr(8'he4, c, 2'h0);
        axi_rd(8'he4, {24'h0, c}, 2'h0);
        @(posedge aclk);
        pins_cmd <= k[0] ? p : ~p;
        repeat (10) @(negedge aclk);
        chk({30'h0, irq_b_req, irq_a_req}, 32'h3);
        @(posedge aclk);
        pins_cmd <= k[0] ? ~p : p;
        repeat (10) @(negedge aclk);
        chk({30'h0, irq_b_req, irq_a_req}, 32'h0);
      end
    end
    $display("pin select test done");
  endtask : test_pins

  task test_edge;
    @(posedge aclk);
    pins_cmd <= 8'h00;
    axi_wr(8'he4, 8'haa, 2'h0);
    repeat (10) @(negedge aclk);
    axi_wr(8'h88, 8'h03, 2'h0);
    // flags latched by earlier pin activity are dropped before the real edge
    @(posedge aclk);
    vector_ack_a <= 1'b1;
    vector_ack_b <= 1'b1;
    @(posedge aclk);
    vector_ack_a <= 1'b0;
    vector_ack_b <= 1'b0;
    @(negedge aclk);
    chk({30'h0, irq_b_req, irq_a_req}, 32'h0);
    @(posedge aclk);
    pins_cmd <= 8'h04;
    // the clear meets the edge in the same cycle, so the set has to win
    repeat (6) @(posedge aclk);
    vector_ack_a <= 1'b1;
    @(posedge aclk);
    vector_ack_a <= 1'b0;
    repeat (3) @(posedge aclk);
    pins_cmd <= 8'h00;
    repeat (10) @(negedge aclk);
    chk({30'h0, irq_b_req, irq_a_req}, 32'h3);
    @(posedge aclk);
    vector_ack_a <= 1'b1;
    @(posedge aclk);
    vector_ack_a <= 1'b0;
    vector_ack_b <= 1'b1;
    @(negedge aclk);
    chk({30'h0, irq_b_req, irq_a_req}, 32'h2);
    @(posedge aclk);
    vector_ack_b <= 1'b0;
    repeat (2) @(negedge aclk);
    chk({30'h0, irq_b_req, irq_a_req}, 32'h0);
    axi_wr(8'h88, 8'h00, 2'h0);
    axi_wr(8'he4, 8'h01, 2'h0);
    $display("edge test done");
  endtask : test_edge

  task test_idle;
    @(posedge aclk);
    pins_cmd <= 8'hff;
    irq_enable <= 2'b01;
    repeat (10) @(negedge aclk);
    enter(8'h01);
    chkb(cpu_clk_en, 1'b0);
    chkb(periph_clk_en, 1'b1);
    axi_rd(8'h80, 32'h0, 2'h0);
    axi_rd(8'h8c, 32'h11, 2'h0);
    @(posedge aclk);
    pins_cmd <= 8'hfd;
    repeat (10) @(negedge aclk);
    chkb(cpu_clk_en, 1'b1);
    axi_rd(8'h8c, 32'h14, 2'h0);
    @(posedge aclk);
    pins_cmd <= 8'hff;
    repeat (10) @(negedge aclk);
    enter(8'h01);
    chkb(cpu_clk_en, 1'b0);
    @(posedge aclk);
    wdt_timeout <= 1'b1;
    rst_seq;
    $display("idle test done");
  endtask : test_idle

  task test_stop;
    axi_wr(8'h88, 8'h04, 2'h0);
    enter(8'h02);
    chk({28'h0, cpu_clk_en, periph_clk_en, osc_en, regulator_en}, 32'h1);
    @(posedge aclk);
    pins_cmd <= 8'hfd;
    repeat (12) @(negedge aclk);
    chkb(cpu_clk_en, 1'b0);
    @(posedge aclk);
    lost_clock_timeout <= 1'b1;
    rst_seq;
    axi_rd(8'h88, 32'h0, 2'h0);
    $display("stop test done");
  endtask : test_stop

  task test_reg_off;
    @(posedge aclk);
    pins_cmd <= 8'hff;
    axi_wr(8'hc8, 8'h01, 2'h0);
    enter(8'h02);
    chkb(regulator_en, 1'b0);
    @(posedge aclk);
    wdt_timeout <= 1'b1;
    repeat (12) @(posedge aclk);
    wdt_timeout <= 1'b0;
    @(negedge aclk);
    chk({30'h0, sys_reset, cpu_clk_en}, 32'h0);
    @(posedge aclk);
    ext_reset_pin_n <= 1'b0;
    rst_seq;
    chkb(regulator_en, 1'b1);
    $display("regulator off test done");
  endtask : test_reg_off

  task complete_run;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  // the tests take under a thousand cycles of the 4 ns clock, so this span leaves a wide margin
  initial begin
    #60000;
    miscompares++;
    complete_run;
  end

  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, instr_done, other_irq_wake} = 7'h0;
    {vector_ack_a, vector_ack_b, wdt_timeout, lost_clock_timeout} = 4'h0;
    ext_reset_pin_n = 1'b1;
    {awaddr, araddr, xbar_skip, wdata} = 56'h0;
    wstrb = 4'hf;
    irq_enable = 2'b00;
    pins_cmd = 8'hff;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    test_regs;
    test_xbar;
    test_pins;
    test_edge;
    test_idle;
    test_stop;
    test_reg_off;
    complete_run;
  end
endmodule : power_mode_and_ext_irq_config_test
